//--- logic/oicsel_top.sv
// Oscillator input clock select: AXI4-Lite registers, source selection and pulse output.
// Assumes aclk at 250 MHz; the three external sources are asynchronous and slower than aclk/2.
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "oicsel_params.svh"
module oicsel_top
  import oicsel_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_clock_pin,
  input wire logic logic_cell_one_output,
  input wire logic fast_internal_oscillator,
  input wire logic accumulator_overflow,
  output logic osc_pulse_out,
  output logic pulse_frequency_mode
);
  oicsel_pulse_if pif ();

  logic [7:0] osc_input_clock_control;
  logic [7:0] next_clock_control;
  logic next_mode;
  logic [7:0] aw_addr;
  logic [7:0] next_aw_addr;
  logic aw_held;
  logic next_aw_held;
  logic [7:0] w_data;
  logic [7:0] next_w_data;
  logic w_strb0;
  logic next_w_strb0;
  logic w_held;
  logic next_w_held;
  logic bvalid;
  logic next_bvalid;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  logic rvalid;
  logic next_rvalid;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0] rresp;
  logic [1:0] next_rresp;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic pulse_q;
  logic next_awready;
  logic next_wready;
  logic next_arready;

  // Sources in order: fast oscillator, logic cell, external pin
  logic [2:0] src_meta;
  logic [2:0] src_sync;
  logic [2:0] src_last;
  logic tick;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_meta <= 3'h0;
      src_sync <= 3'h0;
      src_last <= 3'h0;
    end else if (ce) begin
      src_meta <= {external_clock_pin, logic_cell_one_output, fast_internal_oscillator};
      src_sync <= src_meta;
      src_last <= src_sync;
    end
  end

  // Rising edges of a synchronised source are its ticks; the system clock ticks every cycle
  always_comb begin
    case (oicsel_src_t'(osc_input_clock_control[`OICSEL_CKS_MSB:`OICSEL_CKS_LSB]))
      OICSEL_SRC_FAST_OSC: tick = src_sync[0] & ~src_last[0];
      OICSEL_SRC_SYSTEM: tick = 1'b1;
      OICSEL_SRC_LOGIC_CELL: tick = src_sync[1] & ~src_last[1];
      OICSEL_SRC_EXT_PIN: tick = src_sync[2] & ~src_last[2];
      default: tick = 1'b0;
    endcase
  end

  assign pif.tick = tick;
  assign pif.overflow = accumulator_overflow;
  assign pif.pulse_frequency_mode = pulse_frequency_mode;
  assign pif.pulse_width_select = osc_input_clock_control[`OICSEL_PWS_MSB:`OICSEL_PWS_LSB];
  assign pulse_q = pif.pulse;
  assign osc_pulse_out = pulse_q;

  oicsel_pulse u_pulse (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pif(pif.gen)
  );

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;

  // Address and data are held until both have arrived; the register write happens then
  always_comb begin
    next_aw_addr = aw_addr;
    next_aw_held = aw_held;
    next_w_data = w_data;
    next_w_strb0 = w_strb0;
    next_w_held = w_held;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_clock_control = osc_input_clock_control;
    next_mode = pulse_frequency_mode;
    if (aw_take) begin
      next_aw_addr = s_axi_awaddr;
      next_aw_held = 1'b1;
    end
    if (w_take) begin
      next_w_data = s_axi_wdata[7:0];
      next_w_strb0 = s_axi_wstrb[0];
      next_w_held = 1'b1;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = OICSEL_RESP_OKAY;
      case ({aw_addr[7:2], 2'h0})
        `OICSEL_CLK_CTRL_ADDR: begin
          if (w_strb0) begin
            next_clock_control = w_data & `OICSEL_CLK_CTRL_MASK;
          end
        end
        `OICSEL_MODE_ADDR: begin
          if (w_strb0) begin
            next_mode = w_data[0];
          end
        end
        `OICSEL_STATUS_ADDR: begin
        end
        default: next_bresp = OICSEL_RESP_SLVERR;
      endcase
    end
    next_awready = ~next_aw_held & ~next_bvalid;
    next_wready = ~next_w_held & ~next_bvalid;
  end

  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (ar_take) begin
      next_rvalid = 1'b1;
      next_rresp = OICSEL_RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'h0})
        `OICSEL_CLK_CTRL_ADDR: next_rdata = {24'h00_0000, osc_input_clock_control};
        `OICSEL_MODE_ADDR: next_rdata = {31'h0000_0000, pulse_frequency_mode};
        `OICSEL_STATUS_ADDR: next_rdata = {29'h0000_0000, tick, src_sync[2], pulse_q};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = OICSEL_RESP_SLVERR;
        end
      endcase
    end
    next_arready = ~next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_input_clock_control <= `OICSEL_CLK_CTRL_RESET;
      pulse_frequency_mode <= `OICSEL_MODE_RESET;
      aw_addr <= 8'h00;
      aw_held <= 1'b0;
      w_data <= 8'h00;
      w_strb0 <= 1'b0;
      w_held <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_arready <= 1'b1;
    end else if (ce) begin
      osc_input_clock_control <= next_clock_control;
      pulse_frequency_mode <= next_mode;
      aw_addr <= next_aw_addr;
      aw_held <= next_aw_held;
      w_data <= next_w_data;
      w_strb0 <= next_w_strb0;
      w_held <= next_w_held;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      // Ready flags follow the next held/valid state, so the bus sees flop outputs only
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_arready <= next_arready;
    end
  end

  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
endmodule : oicsel_top

//--- logic/oicsel_params.svh
// Offsets, field positions, reset values and widths for the oscillator input clock select block.
// Assumes a 32-bit AXI4-Lite slave port with one aligned word per register.
// Behaviour
// - Pulse width code 000..111 in bits 7:5 gives 1, 2, 4 ... 128 periods of the selected clock.
// - Source code in bits 1:0 picks the clock: 11 pin, 10 logic cell, 01 system, 00 16 MHz oscillator.
// - The pulse width code acts only in pulse frequency mode and is ignored in fixed duty mode.
// - Bits 4:2 of the clock control register read as zero and ignore writes.
// - Every reset clears the clock control register, giving one period and the 16 MHz source.
`ifndef OICSEL_PARAMS_SVH
`define OICSEL_PARAMS_SVH
`define OICSEL_CLK_CTRL_ADDR 8'h00
`define OICSEL_MODE_ADDR 8'h04
`define OICSEL_STATUS_ADDR 8'h08
`define OICSEL_PWS_MSB 7
`define OICSEL_PWS_LSB 5
`define OICSEL_CKS_MSB 1
`define OICSEL_CKS_LSB 0
`define OICSEL_CLK_CTRL_MASK 8'hE3
`define OICSEL_CLK_CTRL_RESET 8'h00
`define OICSEL_MODE_RESET 1'b0
`define OICSEL_CNT_W 7
`define OICSEL_SYNC_STAGES 2
`endif

//--- logic/oicsel_pkg.sv
// Types shared by the oscillator input clock select block.
// Assumes nothing of its surroundings.
package oicsel_pkg;
  typedef enum logic [1:0] {
    OICSEL_SRC_FAST_OSC = 2'h0,
    OICSEL_SRC_SYSTEM = 2'h1,
    OICSEL_SRC_LOGIC_CELL = 2'h2,
    OICSEL_SRC_EXT_PIN = 2'h3
  } oicsel_src_t;
  typedef enum logic [1:0] {
    OICSEL_RESP_OKAY = 2'h0,
    OICSEL_RESP_SLVERR = 2'h2
  } oicsel_resp_t;
endpackage : oicsel_pkg

//--- logic/oicsel_pulse_if.sv
// Carrier between the register block and the pulse generator.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface oicsel_pulse_if;
  logic tick;
  logic overflow;
  logic pulse_frequency_mode;
  logic [2:0] pulse_width_select;
  logic pulse;
  modport ctl (output tick, output overflow, output pulse_frequency_mode,
    output pulse_width_select, input pulse);
  modport gen (input tick, input overflow, input pulse_frequency_mode,
    input pulse_width_select, output pulse);
endinterface : oicsel_pulse_if

//--- logic/oicsel_pulse.sv
// Output pulse generator: in pulse frequency mode stretches each overflow over a count of selected-clock ticks; in fixed duty mode toggles on it.
// Assumes tick and overflow are one-cycle strobes on aclk.
`timescale 1ns/1ps
`include "oicsel_params.svh"
module oicsel_pulse
  import oicsel_pkg::*;
#(
  parameter int CNT_W = `OICSEL_CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  oicsel_pulse_if.gen pif
);
  logic pulse;
  logic next_pulse;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  always_comb begin
    next_pulse = pulse;
    next_count = count;
    if (pif.overflow) begin
      if (pif.pulse_frequency_mode) begin
        // Width is 2**code periods; the count holds one less than the periods still to run
        next_pulse = 1'b1;
        next_count = CNT_W'((1 << pif.pulse_width_select) - 1);
      end else begin
        // Fixed duty mode ignores the width code entirely
        next_pulse = ~pulse;
      end
    end else if (pif.pulse_frequency_mode && pulse && pif.tick) begin
      if (count == '0) begin
        next_pulse = 1'b0;
      end else begin
        next_count = count - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse <= 1'b0;
      count <= '0;
    end else if (ce) begin
      pulse <= next_pulse;
      count <= next_count;
    end
  end

  assign pif.pulse = pulse;
endmodule : oicsel_pulse

//--- bench/oicsel_chk.sv
// Checker for oicsel_top: bus handshakes, reserved bits, reset and output pulse.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module oicsel_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic accumulator_overflow,
  input wire logic osc_pulse_out,
  input wire logic pulse_frequency_mode
);
  logic [7:0] rd_addr;
  // Address of the read in flight, so read data can be judged by register
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_addr <= s_axi_araddr;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
    else $error("no read data one cycle after address taken");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  a_reserved_zero: assert property (s_axi_rvalid && rd_addr == 8'h00 |->
    s_axi_rdata[4:2] == 3'b000 && s_axi_rdata[31:8] == 24'h00_0000)
    else $error("unimplemented control bits read nonzero");
  a_pfm_start: assert property (ce && pulse_frequency_mode && accumulator_overflow |=> osc_pulse_out)
    else $error("overflow did not start the pulse");
  a_fixed_toggle: assert property (ce && !pulse_frequency_mode && accumulator_overflow |=>
    osc_pulse_out != $past(osc_pulse_out))
    else $error("fixed duty output did not toggle on overflow");
  a_reset_clear: assert property (disable iff (1'b0) !aresetn |=> !osc_pulse_out && !pulse_frequency_mode)
    else $error("outputs not cleared by reset");
  c_pfm: cover property (pulse_frequency_mode && accumulator_overflow);
  c_fall: cover property ($fell(osc_pulse_out));
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : oicsel_chk
bind oicsel_top oicsel_chk u_chk (.aclk, .aresetn, .ce, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .accumulator_overflow, .osc_pulse_out, .pulse_frequency_mode);

//--- bench/oicsel_tb.sv
// Self-checking bench for oicsel_top: registers over AXI4-Lite, source select, pulse width.
// Assumes the design files under logic/ and the checker are compiled first.
`timescale 1ns/1ps
`include "oicsel_params.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module oicsel_tb;
  import oicsel_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, accumulator_overflow = 1'b0, o0, ce = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'h0, src_lvl = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic osc_pulse_out, pulse_frequency_mode;
  int err_total = 0, samples_checked = 0, cyc = 0, n;
  int sels[3] = '{0, 2, 3};
  always #2 aclk = ~aclk;
  // Source 1 is the system clock, so src_lvl[1] has no pin
  oicsel_top uut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .external_clock_pin(src_lvl[3]),
    .logic_cell_one_output(src_lvl[2]), .fast_internal_oscillator(src_lvl[0]),
    .accumulator_overflow, .osc_pulse_out, .pulse_frequency_mode);
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd_reg
  // One-cycle overflow strobe; pulse frequency mode callers wait for the pulse to end first
  task automatic fire;
    accumulator_overflow <= 1'b1;
    @(posedge aclk);
    accumulator_overflow <= 1'b0;
  endtask : fire
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : do_reset
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    do_reset();
    rd_reg(`OICSEL_CLK_CTRL_ADDR);
    `CHK("ctrl reset", 32'h0000_0000, rd)
    rd_reg(`OICSEL_MODE_ADDR);
    `CHK("mode reset", 32'h0000_0000, rd)
    wr(`OICSEL_CLK_CTRL_ADDR, 32'h0000_00FF);
    rd_reg(`OICSEL_CLK_CTRL_ADDR);
    `CHK("ctrl readback", 32'h0000_00E3, rd)
    wr(8'h0C, 32'h0000_0001);
    `CHK("unmapped bresp", 2'h2, rs)
    rd_reg(8'h0C);
    `CHK("unmapped rresp", 2'h2, rs)
    do_reset();
    rd_reg(`OICSEL_CLK_CTRL_ADDR);
    `CHK("ctrl second reset", 32'h0000_0000, rd)
    $display("register test done");
    wr(`OICSEL_MODE_ADDR, 32'h0000_0001);
    `CHK("mode out set", 1'b1, pulse_frequency_mode)
    // System clock ticks every cycle, so width in cycles equals the tick count
    for (int c = 0; c < 8; c++) begin
      wr(`OICSEL_CLK_CTRL_ADDR, 32'(c * 32 + 1));
      fire();
      n = 0;
      @(posedge aclk);
      while (osc_pulse_out && n < 300) begin
        n++;
        @(posedge aclk);
      end
      `CHK("pulse width", 1 << c, n)
    end
    $display("pulse width test done");
    for (int i = 0; i < 3; i++) begin
      wr(`OICSEL_CLK_CTRL_ADDR, 32'(sels[i]));
      fire();
      repeat (10) @(posedge aclk);
      `CHK("pulse held", 1'b1, osc_pulse_out)
      src_lvl[sels[i]] <= 1'b1;
      repeat (8) @(posedge aclk);
      `CHK("pulse ended", 1'b0, osc_pulse_out)
      src_lvl <= 4'h0;
    end
    $display("source select test done");
    wr(`OICSEL_MODE_ADDR, 32'h0000_0000);
    `CHK("mode out clear", 1'b0, pulse_frequency_mode)
    wr(`OICSEL_CLK_CTRL_ADDR, 32'h0000_00E1);
    o0 = osc_pulse_out;
    for (int k = 0; k < 2; k++) begin
      fire();
      @(posedge aclk);
      o0 = ~o0;
      `CHK("fixed duty toggle", o0, osc_pulse_out)
    end
    // With the clock enable low an overflow must leave the output frozen
    ce <= 1'b0;
    fire();
    @(posedge aclk);
    `CHK("frozen by ce", o0, osc_pulse_out)
    ce <= 1'b1;
    $display("fixed duty test done");
    finish_test();
  end
endmodule : oicsel_tb
